// >>> cfa_core.sv
// condition code register, mac flags and effective address generation
// *****************************************************************************
// How it works
// - stop bit clear halts clock, set is no-op
// - mac overflow flag on overflow into bit 35
// - half carry from bit 3 on byte add
// - extension overflow flag on overflow into bit 31
// - n from result msb, z on all-zero result
// - v on two's complement signed overflow, n xor c on shifts
// - carry from arithmetic, shifted through on shifts
// - three-bit mask holds level 0 to 7
// - saturate mode clamps mac reads after overflow
// - pc extension above pc gives 20 bits
// - bytes anywhere, word at lower byte address
// - instruction fetches always word aligned
// - misaligned word becomes two byte transfers
// - upper address carries in immediate and indexed modes and on a split word's second byte, bank field stays
// - immediate is next byte; short add sign-extends
// - extended mode joins ek with operand word
// - 8-bit indexed adds unsigned byte offset
// - 16-bit indexed adds signed word offset
// - 20-bit indexed adds signed 20-bit offset
// - accumulator offset adds e to index
// - taken branch adds signed offset to pc
// - memory move uses x then adds offset
// *****************************************************************************
module cfa_core (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  output logic      [15:0] o_reg_rdata,
  // alu result port
  input  wire logic        i_alu_valid,
  input  wire logic [2:0]  i_alu_op,
  input  wire logic        i_alu_byte,
  input  wire logic        i_alu_sext8,
  input  wire logic [15:0] i_alu_a,
  input  wire logic [15:0] i_alu_b,
  output logic      [15:0] o_alu_result,
  // mac port
  input  wire logic        i_mac_valid,
  input  wire logic [35:0] i_mac_addend,
  input  wire logic        i_mac_read,
  input  wire logic        i_mac_read_ext,
  output logic      [31:0] o_mac_data,
  output logic             o_mac_data_valid,
  // low power stop
  input  wire logic        i_low_power_stop_instr,
  input  wire logic        i_wake,
  output logic             o_clock_stop,
  output logic      [2:0]  o_int_level,
  output logic      [19:0] o_pc_addr,
  // effective address request
  input  wire logic        i_ea_valid,
  input  wire logic [3:0]  i_ea_mode,
  input  wire logic [1:0]  i_ea_index,
  input  wire logic [19:0] i_ea_operand,
  input  wire logic        i_ea_word,
  input  wire logic        i_ea_fetch,
  output logic             o_ea_busy,
  output logic             o_xfer_valid,
  output logic      [19:0] o_xfer_addr,
  output logic             o_xfer_word
);

  // *****************************************************************************
  // state
  // *****************************************************************************
  logic [15:0] ccr_r, bank_r, ix_r, iy_r, iz_r, acc_e_r, pc_r;
  logic [35:0] am_r;
  logic        sign_before_r;
  logic        stop_r;
  logic [15:0] rdata_r;
  logic [31:0] mac_data_r;
  logic        mac_valid_r;
  cfa_pkg::cfa_xfer_state_t xf_state_r;
  logic [19:0] xf_addr_r;
  logic        xf_valid_r;
  logic        xf_word_r;

  // *****************************************************************************
  // alu datapath
  // *****************************************************************************
  wire [15:0] alu_b    = i_alu_sext8 ? {{8{i_alu_b[7]}}, i_alu_b[7:0]} : i_alu_b;
  wire        op_adc   = (i_alu_op == cfa_pkg::ALU_ADC) || (i_alu_op == cfa_pkg::ALU_SBC);
  wire        c_in     = ccr_r[cfa_pkg::CCR_C];
  wire        a_cin    = op_adc & c_in;
  wire        is_sub   = (i_alu_op == cfa_pkg::ALU_SUB) || (i_alu_op == cfa_pkg::ALU_SBC);
  wire        is_shift = i_alu_op[2];
  wire [16:0] add_w    = {1'b0, i_alu_a} + {1'b0, alu_b} + {16'h0000, a_cin};
  wire [16:0] sub_w    = {1'b0, i_alu_a} - {1'b0, alu_b} - {16'h0000, a_cin};
  wire [8:0]  add_b    = {1'b0, i_alu_a[7:0]} + {1'b0, alu_b[7:0]} + {8'h00, a_cin};
  wire [8:0]  sub_b    = {1'b0, i_alu_a[7:0]} - {1'b0, alu_b[7:0]} - {8'h00, a_cin};
  wire [4:0]  half_sum = {1'b0, i_alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, a_cin};
  wire        rot_in   = i_alu_op[0] & c_in;
  wire [15:0] src      = i_alu_byte ? {8'h00, i_alu_a[7:0]} : i_alu_a;
  wire        src_msb  = i_alu_byte ? i_alu_a[7] : i_alu_a[15];
  wire [15:0] shl      = i_alu_byte ? {8'h00, i_alu_a[6:0], rot_in} : {i_alu_a[14:0], rot_in};
  wire [15:0] shr      = i_alu_byte ? {8'h00, rot_in, i_alu_a[7:1]} : {rot_in, i_alu_a[15:1]};
  wire [15:0] arith_r  = i_alu_byte ? {8'h00, is_sub ? sub_b[7:0] : add_b[7:0]}
                                    : (is_sub ? sub_w[15:0] : add_w[15:0]);
  wire        arith_c  = i_alu_byte ? (is_sub ? sub_b[8] : add_b[8])
                                    : (is_sub ? sub_w[16] : add_w[16]);
  wire [15:0] alu_res  = !is_shift ? arith_r : (i_alu_op[1] ? shr : shl);
  wire        alu_c    = !is_shift ? arith_c : (i_alu_op[1] ? src[0] : src_msb);
  wire        res_msb  = i_alu_byte ? alu_res[7] : alu_res[15];
  wire        res_zero = i_alu_byte ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
  wire        b_msb    = i_alu_byte ? alu_b[7] : alu_b[15];
  wire        ar_ovf   = is_sub ? (src_msb != b_msb) && (res_msb != src_msb)
                                : (src_msb == b_msb) && (res_msb != src_msb);
  wire        alu_v    = is_shift ? (res_msb ^ alu_c) : ar_ovf;
  wire        h_upd    = i_alu_byte && !is_shift && !is_sub;

  // *****************************************************************************
  // mac accumulate and saturated read
  // *****************************************************************************
  wire [36:0] mac_sum  = {am_r[35], am_r} + {i_mac_addend[35], i_mac_addend};
  wire [35:0] am_nxt   = mac_sum[35:0];
  wire        mv_evt   = mac_sum[36] ^ mac_sum[35];
  wire        ev_evt   = !((am_nxt[35:31] == 5'h00) || (am_nxt[35:31] == 5'h1f));
  wire        ovf_any  = ccr_r[cfa_pkg::CCR_MV] | ccr_r[cfa_pkg::CCR_EV];
  wire        sat_on   = ccr_r[cfa_pkg::CCR_SM] & ovf_any;
  wire [15:0] rnd_val  = am_r[31:16] + {15'h0000, am_r[15]};
  wire [31:0] sat_ext  = sign_before_r ? cfa_pkg::SAT_NEG_EXT : cfa_pkg::SAT_POS_EXT;
  wire [15:0] sat_rnd  = sign_before_r ? cfa_pkg::SAT_NEG_RND : cfa_pkg::SAT_POS_RND;
  wire [31:0] mac_rd   = i_mac_read_ext ? (sat_on ? sat_ext : am_r[31:0])
                                        : {16'h0000, sat_on ? sat_rnd : rnd_val};

  // *****************************************************************************
  // condition code next value
  // *****************************************************************************
  wire        wr_ccr   = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_CCR);
  wire [15:0] ccr_sw   = wr_ccr ? i_reg_wdata : ccr_r;
  logic [15:0] ccr_nxt;
  always_comb begin
    ccr_nxt = ccr_sw;
    // hardware updates follow the software write so that a same-cycle event is kept
    if (i_alu_valid) begin
      ccr_nxt[cfa_pkg::CCR_N] = res_msb;
      ccr_nxt[cfa_pkg::CCR_Z] = res_zero;
      ccr_nxt[cfa_pkg::CCR_V] = alu_v;
      ccr_nxt[cfa_pkg::CCR_C] = alu_c;
      if (h_upd) begin
        ccr_nxt[cfa_pkg::CCR_H] = half_sum[4];
      end
    end
    if (i_mac_valid) begin
      ccr_nxt[cfa_pkg::CCR_MV] = ccr_sw[cfa_pkg::CCR_MV] | mv_evt;
      ccr_nxt[cfa_pkg::CCR_EV] = ev_evt;
    end
  end
  wire sign_cap = i_mac_valid && (mv_evt || ev_evt) && !ovf_any;

  // *****************************************************************************
  // effective address generation
  // *****************************************************************************
  wire [3:0]  ek      = bank_r[cfa_pkg::BANK_EK +: 4];
  wire [3:0]  xk      = bank_r[cfa_pkg::BANK_XK +: 4];
  wire [3:0]  pk      = ccr_r[cfa_pkg::CCR_PK +: 4];
  wire [19:0] full_x  = {xk, ix_r};
  wire [19:0] full_y  = {bank_r[cfa_pkg::BANK_YK +: 4], iy_r};
  wire [19:0] full_z  = {bank_r[cfa_pkg::BANK_ZK +: 4], iz_r};
  wire [19:0] idx_sel = (i_ea_index == cfa_pkg::IDX_Y) ? full_y
                      : (i_ea_index == cfa_pkg::IDX_Z) ? full_z : full_x;
  wire [15:0] sext8   = {{8{i_ea_operand[7]}}, i_ea_operand[7:0]};
  wire [15:0] pc_rel  = pc_r + ((i_ea_mode == cfa_pkg::EA_REL8) ? sext8 : i_ea_operand[15:0]);
  wire [19:0] pc_full = {pk, pc_r};
  logic [19:0] ea;
  always_comb begin
    unique case (cfa_pkg::cfa_ea_mode_t'(i_ea_mode))
      cfa_pkg::EA_IMM:     ea = pc_full + i_ea_operand;
      cfa_pkg::EA_EXT:     ea = {ek, i_ea_operand[15:0]};
      cfa_pkg::EA_IND8:    ea = idx_sel + {12'h000, i_ea_operand[7:0]};
      cfa_pkg::EA_IND16:   ea = idx_sel + {{4{i_ea_operand[15]}}, i_ea_operand[15:0]};
      cfa_pkg::EA_IND20:   ea = idx_sel + i_ea_operand;
      cfa_pkg::EA_ACCOFF:  ea = idx_sel + {4'h0, acc_e_r};
      cfa_pkg::EA_REL8,
      cfa_pkg::EA_REL16:   ea = {pk, pc_rel};
      cfa_pkg::EA_POSTMOD: ea = full_x;
      default:             ea = pc_full;
    endcase
  end

  // carry out of bit 15 moves ea[19:16] in the immediate and indexed modes while the bank fields stay put; relative modes keep pk
  wire        ea_take  = i_ea_valid && (xf_state_r == cfa_pkg::XF_IDLE);
  wire        ea_split = i_ea_word && !i_ea_fetch && ea[0];
  wire [19:0] ea_first = i_ea_fetch ? {ea[19:1], 1'b0} : ea;
  wire [19:0] ea_next  = xf_addr_r + 20'h00001;
  wire        is_rel   = (i_ea_mode == cfa_pkg::EA_REL8) || (i_ea_mode == cfa_pkg::EA_REL16);
  wire        is_pm    = (i_ea_mode == cfa_pkg::EA_POSTMOD);

  // *****************************************************************************
  // register read decode
  // *****************************************************************************
  wire [15:0] status_w = {14'h0000, xf_state_r == cfa_pkg::XF_SECOND, stop_r};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (i_reg_addr)
      cfa_pkg::ADDR_CCR:    rd_mux = ccr_r;
      cfa_pkg::ADDR_BANK:   rd_mux = bank_r;
      cfa_pkg::ADDR_IDX_X:  rd_mux = ix_r;
      cfa_pkg::ADDR_IDX_Y:  rd_mux = iy_r;
      cfa_pkg::ADDR_IDX_Z:  rd_mux = iz_r;
      cfa_pkg::ADDR_ACC_E:  rd_mux = acc_e_r;
      cfa_pkg::ADDR_PC:     rd_mux = pc_r;
      cfa_pkg::ADDR_AM_LO:  rd_mux = am_r[15:0];
      cfa_pkg::ADDR_AM_MID: rd_mux = am_r[31:16];
      cfa_pkg::ADDR_AM_HI:  rd_mux = {12'h000, am_r[35:32]};
      cfa_pkg::ADDR_STATUS: rd_mux = status_w;
      default:              rd_mux = 16'h0000;
    endcase
  end

  wire wr_bank = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_BANK);
  wire wr_ix   = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_IDX_X);
  wire wr_iy   = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_IDX_Y);
  wire wr_iz   = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_IDX_Z);
  wire wr_e    = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_ACC_E);
  wire wr_pc   = i_reg_write && (i_reg_addr == cfa_pkg::ADDR_PC);
  // post-modify wraps inside ix; xk is not touched
  wire [15:0] ix_nxt = (ea_take && is_pm) ? ix_r + sext8 : (wr_ix ? i_reg_wdata : ix_r);
  wire [15:0] pc_nxt = (ea_take && is_rel) ? pc_rel : (wr_pc ? i_reg_wdata : pc_r);
  wire        stop_nxt = i_wake ? 1'b0
                       : ((i_low_power_stop_instr && !ccr_r[cfa_pkg::CCR_S]) ? 1'b1 : stop_r);

  // *****************************************************************************
  // registers
  // *****************************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ccr_r         <= cfa_pkg::CCR_RESET;
      bank_r        <= cfa_pkg::BANK_RESET;
      ix_r          <= cfa_pkg::WORD_RESET;
      iy_r          <= cfa_pkg::WORD_RESET;
      iz_r          <= cfa_pkg::WORD_RESET;
      acc_e_r       <= cfa_pkg::WORD_RESET;
      pc_r          <= cfa_pkg::WORD_RESET;
    end else begin
      ccr_r         <= ccr_nxt;
      bank_r        <= wr_bank ? i_reg_wdata : bank_r;
      ix_r          <= ix_nxt;
      iy_r          <= wr_iy ? i_reg_wdata : iy_r;
      iz_r          <= wr_iz ? i_reg_wdata : iz_r;
      acc_e_r       <= wr_e ? i_reg_wdata : acc_e_r;
      pc_r          <= pc_nxt;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      am_r          <= 36'h000000000;
      sign_before_r <= 1'b0;
      stop_r        <= 1'b0;
      rdata_r       <= 16'h0000;
      mac_data_r    <= 32'h00000000;
      mac_valid_r   <= 1'b0;
      o_alu_result  <= 16'h0000;
    end else begin
      am_r          <= i_mac_valid ? am_nxt : am_r;
      sign_before_r <= sign_cap ? am_r[35] : sign_before_r;
      stop_r        <= stop_nxt;
      rdata_r       <= i_reg_read ? rd_mux : 16'h0000;
      mac_data_r    <= i_mac_read ? mac_rd : mac_data_r;
      mac_valid_r   <= i_mac_read;
      o_alu_result  <= i_alu_valid ? alu_res : o_alu_result;
    end
  end

  // two-step transfer: second byte of a misaligned word follows the first
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      xf_state_r    <= cfa_pkg::XF_IDLE;
      xf_addr_r     <= 20'h00000;
      xf_valid_r    <= 1'b0;
      xf_word_r     <= 1'b0;
    end else begin
      unique case (xf_state_r)
        cfa_pkg::XF_IDLE: begin
          xf_valid_r <= ea_take;
          xf_addr_r  <= ea_take ? ea_first : xf_addr_r;
          xf_word_r  <= ea_take && (i_ea_word || i_ea_fetch) && !ea_split;
          xf_state_r <= (ea_take && ea_split) ? cfa_pkg::XF_SECOND : cfa_pkg::XF_IDLE;
        end
        cfa_pkg::XF_SECOND: begin
          xf_valid_r <= 1'b1;
          xf_addr_r  <= ea_next;
          xf_word_r  <= 1'b0;
          xf_state_r <= cfa_pkg::XF_IDLE;
        end
      endcase
    end
  end

  assign o_reg_rdata      = rdata_r;
  assign o_mac_data       = mac_data_r;
  assign o_mac_data_valid = mac_valid_r;
  assign o_clock_stop     = stop_r;
  assign o_int_level      = ccr_r[cfa_pkg::CCR_INT +: 3];
  assign o_pc_addr        = pc_full;
  assign o_ea_busy        = (xf_state_r == cfa_pkg::XF_SECOND);
  assign o_xfer_valid     = xf_valid_r;
  assign o_xfer_addr      = xf_addr_r;
  assign o_xfer_word      = xf_word_r;

  // *****************************************************************************
  // assertions
  // *****************************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sequence split_req_s;
    ea_take && ea_split;
  endsequence
  sequence two_bytes_s;
    o_xfer_valid && !o_xfer_word ##1 o_xfer_valid && !o_xfer_word;
  endsequence

  stop_halts_a: assert property (
    i_low_power_stop_instr && !i_wake && !ccr_r[cfa_pkg::CCR_S] |=> o_clock_stop)
    else $error("stop not entered");
  stop_nop_a: assert property (
    i_low_power_stop_instr && !o_clock_stop && ccr_r[cfa_pkg::CCR_S] |=> !o_clock_stop)
    else $error("stop taken while disabled");
  mv_sticky_a: assert property (
    i_mac_valid && mv_evt |=> ccr_r[cfa_pkg::CCR_MV])
    else $error("mac overflow flag not set");
  half_carry_a: assert property (
    i_alu_valid && h_upd |=> ccr_r[cfa_pkg::CCR_H] == $past(half_sum[4]))
    else $error("half carry wrong");
  ev_flag_a: assert property (
    i_mac_valid |=> ccr_r[cfa_pkg::CCR_EV] == (am_r[35:31] != 5'h00 && am_r[35:31] != 5'h1f))
    else $error("extension overflow flag wrong");
  zero_flag_a: assert property (
    i_alu_valid && !i_alu_byte |=> ccr_r[cfa_pkg::CCR_Z] == (o_alu_result == 16'h0000))
    else $error("zero flag disagrees with result");
  neg_flag_a: assert property (
    i_alu_valid && !i_alu_byte |=> ccr_r[cfa_pkg::CCR_N] == o_alu_result[15])
    else $error("negative flag disagrees with result");
  shift_carry_a: assert property (
    i_alu_valid && i_alu_op == cfa_pkg::ALU_ASL && !i_alu_byte
      |=> ccr_r[cfa_pkg::CCR_C] == $past(i_alu_a[15]))
    else $error("shift carry wrong");
  sat_read_a: assert property (
    i_mac_read && i_mac_read_ext && sat_on
      |=> o_mac_data_valid && (o_mac_data == cfa_pkg::SAT_POS_EXT
                               || o_mac_data == cfa_pkg::SAT_NEG_EXT))
    else $error("saturated read not clamped");
  fetch_align_a: assert property (
    ea_take && i_ea_fetch |=> o_xfer_valid && !o_xfer_addr[0])
    else $error("fetch not word aligned");
  split_pair_a: assert property (
    split_req_s |=> two_bytes_s ##0 (o_xfer_addr == $past(o_xfer_addr) + 20'h00001))
    else $error("misaligned word not split in two bytes");
  ext_mode_a: assert property (
    ea_take && i_ea_mode == cfa_pkg::EA_EXT && !i_ea_word && !i_ea_fetch
      |=> o_xfer_addr == {$past(ek), $past(i_ea_operand[15:0])})
    else $error("extended address wrong");
  postmod_a: assert property (
    ea_take && is_pm && !wr_ix |=> ix_r == $past(ix_r) + $past(sext8) && o_xfer_valid)
    else $error("post-modify of x wrong");

endmodule : cfa_core

// >>> cfa_pkg.sv
// constants and types for the condition code and address generation slice
package cfa_pkg;

  // ***************
  // register map
  // ***************
  localparam logic [3:0] ADDR_CCR    = 4'h0;
  localparam logic [3:0] ADDR_BANK   = 4'h1;
  localparam logic [3:0] ADDR_IDX_X  = 4'h2;
  localparam logic [3:0] ADDR_IDX_Y  = 4'h3;
  localparam logic [3:0] ADDR_IDX_Z  = 4'h4;
  localparam logic [3:0] ADDR_ACC_E  = 4'h5;
  localparam logic [3:0] ADDR_PC     = 4'h6;
  localparam logic [3:0] ADDR_AM_LO  = 4'h7;
  localparam logic [3:0] ADDR_AM_MID = 4'h8;
  localparam logic [3:0] ADDR_AM_HI  = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;

  // ***************
  // condition code layout
  // ***************
  localparam int CCR_S   = 15;
  localparam int CCR_MV  = 14;
  localparam int CCR_H   = 13;
  localparam int CCR_EV  = 12;
  localparam int CCR_N   = 11;
  localparam int CCR_Z   = 10;
  localparam int CCR_V   = 9;
  localparam int CCR_C   = 8;
  localparam int CCR_INT = 5;
  localparam int CCR_SM  = 4;
  localparam int CCR_PK  = 0;

  // bank register: ek in [15:12], xk [11:8], yk [7:4], zk [3:0]
  localparam int BANK_EK = 12;
  localparam int BANK_XK = 8;
  localparam int BANK_YK = 4;
  localparam int BANK_ZK = 0;

  // ***************
  // reset values
  // ***************
  localparam logic [15:0] CCR_RESET  = 16'h80e0;
  localparam logic [15:0] BANK_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ***************
  // saturation values
  // ***************
  localparam logic [31:0] SAT_POS_EXT = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG_EXT = 32'h80000000;
  localparam logic [15:0] SAT_POS_RND = 16'h7fff;
  localparam logic [15:0] SAT_NEG_RND = 16'h8000;

  // ***************
  // enumerations
  // ***************
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_ADC = 3'b001,
    ALU_SUB = 3'b010,
    ALU_SBC = 3'b011,
    ALU_ASL = 3'b100,
    ALU_ROL = 3'b101,
    ALU_LSR = 3'b110,
    ALU_ROR = 3'b111
  } cfa_alu_op_t;

  typedef enum logic [3:0] {
    EA_IMM     = 4'b0000,
    EA_EXT     = 4'b0001,
    EA_IND8    = 4'b0010,
    EA_IND16   = 4'b0011,
    EA_IND20   = 4'b0100,
    EA_ACCOFF  = 4'b0101,
    EA_REL8    = 4'b0110,
    EA_REL16   = 4'b0111,
    EA_POSTMOD = 4'b1000
  } cfa_ea_mode_t;

  localparam logic [1:0] IDX_X = 2'h0;
  localparam logic [1:0] IDX_Y = 2'h1;
  localparam logic [1:0] IDX_Z = 2'h2;

  typedef enum logic {
    XF_IDLE   = 1'b0,
    XF_SECOND = 1'b1
  } cfa_xfer_state_t;

endpackage : cfa_pkg

// >>> cfa_mem_model.sv
// bus-side memory model that counts and screens transfers from the slice
module cfa_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_xfer_valid,
  input  wire logic [19:0] i_xfer_addr,
  input  wire logic        i_xfer_word,
  output logic      [7:0]  o_xfer_count,
  output logic             o_misaligned
);
  timeunit 1ns;
  timeprecision 1ps;
  // a word on an odd byte would straddle two locations, so it is flagged and kept
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_xfer_count <= 8'h00;
      o_misaligned <= 1'b0;
    end else if (i_xfer_valid) begin
      o_xfer_count <= o_xfer_count + 8'h01;
      o_misaligned <= o_misaligned | (i_xfer_word & i_xfer_addr[0]);
    end
  end
endmodule : cfa_mem_model

// >>> tb.sv
// self-checking bench for the condition code and address slice
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
  typedef struct packed {logic [4:0] c; logic [15:0] a, b, r; logic [4:0] f;} cfa_alu_row_t;
  typedef struct packed {logic [3:0] m; logic [1:0] x; logic [19:0] o; logic [1:0] wf;
    logic [19:0] e;} cfa_ea_row_t;
  int          err_count = 0, total_checks = 0;
  logic        clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, wake = 1'b0;
  logic        alu_valid = 1'b0, alu_byte = 1'b0, alu_sext8 = 1'b0, mac_valid = 1'b0;
  logic        mac_read = 1'b0, mac_ext = 1'b0, low_power_stop_instr = 1'b0, ea_valid = 1'b0;
  logic        ea_word = 1'b0, ea_fetch = 1'b0, mac_dv, clk_stop, ea_busy, x_valid, x_word, mis;
  logic [1:0]  ea_index = 2'h0;
  logic [2:0]  alu_op = 3'h0, int_level;
  logic [3:0]  reg_addr = 4'h0, ea_mode = 4'h0;
  logic [7:0]  x_count;
  logic [15:0] reg_wdata = 16'h0000, alu_a = 16'h0000, alu_b = 16'h0000, rdata, alu_res;
  logic [19:0] ea_operand = 20'h00000, pc_addr, x_addr;
  logic [31:0] mac_data;
  logic [35:0] mac_addend = 36'h000000000;
  // control is {op, byte, sext}; carry chains from row to row, h is held outside byte adds
  cfa_alu_row_t alu_rows [12] = '{
    '{5'h00,16'hffff,16'h0001,16'h0000,5'h05}, '{5'h00,16'h7fff,16'h0001,16'h8000,5'h0a},
    '{5'h08,16'h0000,16'h0001,16'hffff,5'h09}, '{5'h10,16'h8000,16'h0000,16'h0000,5'h07},
    '{5'h14,16'h0001,16'h0000,16'h0003,5'h00}, '{5'h1c,16'h0001,16'h0000,16'h0000,5'h07},
    '{5'h04,16'h0001,16'h0001,16'h0003,5'h00}, '{5'h18,16'h0003,16'h0000,16'h0001,5'h03},
    '{5'h0c,16'h0005,16'h0002,16'h0002,5'h00}, '{5'h02,16'h000f,16'h0001,16'h0010,5'h10},
    '{5'h02,16'h0080,16'h0080,16'h0000,5'h07}, '{5'h01,16'h0010,16'h00ff,16'h000f,5'h01}};
  cfa_ea_row_t ea_rows [12] = '{
    '{4'h0,2'h0,20'h00002,2'h0,20'h11236}, '{4'h1,2'h0,20'h01234,2'h0,20'h21234},
    '{4'h2,2'h0,20'h000ff,2'h0,20'h400ef}, '{4'h3,2'h1,20'h0fff0,2'h0,20'h40ff0},
    '{4'h4,2'h2,20'hfff00,2'h0,20'h50000}, '{4'h5,2'h3,20'h00000,2'h0,20'h40010},
    '{4'h8,2'h0,20'h00004,2'h0,20'h3fff0}, '{4'h8,2'h0,20'h000fc,2'h0,20'h3fff4},
    '{4'h1,2'h0,20'h01000,2'h2,20'h21000}, '{4'h6,2'h0,20'h000fe,2'h0,20'h11232},
    '{4'h7,2'h0,20'h00010,2'h0,20'h11242}, '{4'h0,2'h0,20'h00001,2'h1,20'h11242}};
  always #5 clock = ~clock;
  cfa_core dut_u (.i_clock(clock), .i_resetn(resetn), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(rdata),
    .i_alu_valid(alu_valid), .i_alu_op(alu_op), .i_alu_byte(alu_byte), .i_alu_sext8(alu_sext8),
    .i_alu_a(alu_a), .i_alu_b(alu_b), .o_alu_result(alu_res), .i_mac_valid(mac_valid),
    .i_mac_addend(mac_addend), .i_mac_read(mac_read), .i_mac_read_ext(mac_ext),
    .o_mac_data(mac_data), .o_mac_data_valid(mac_dv), .i_low_power_stop_instr(low_power_stop_instr), .i_wake(wake),
    .o_clock_stop(clk_stop), .o_int_level(int_level), .o_pc_addr(pc_addr),
    .i_ea_valid(ea_valid), .i_ea_mode(ea_mode), .i_ea_index(ea_index), .i_ea_operand(ea_operand),
    .i_ea_word(ea_word), .i_ea_fetch(ea_fetch), .o_ea_busy(ea_busy), .o_xfer_valid(x_valid),
    .o_xfer_addr(x_addr), .o_xfer_word(x_word));
  cfa_mem_model mem_u (.i_clock(clock), .i_resetn(resetn), .i_xfer_valid(x_valid),
    .i_xfer_addr(x_addr), .i_xfer_word(x_word), .o_xfer_count(x_count), .o_misaligned(mis));
  task automatic close_out;
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clock) reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clock) reg_read <= 1'b0;
    #1 `CHK(rdata & m, e)
    @(posedge clock);
  endtask : rdchk
  task automatic alu(input cfa_alu_row_t r);
    {alu_op, alu_byte, alu_sext8, alu_a, alu_b, alu_valid} <= {r.c, r.a, r.b, 1'b1};
    @(posedge clock) alu_valid <= 1'b0;
    #1 `CHK(alu_res, r.r)
    rdchk(cfa_pkg::ADDR_CCR, 16'h2f00, {2'h0, r.f[4], 1'b0, r.f[3:0], 8'h00});
  endtask : alu
  task automatic ea(input cfa_ea_row_t r);
    {ea_mode, ea_index, ea_operand, ea_word, ea_fetch, ea_valid} <= {r.m, r.x, r.o, r.wf, 1'b1};
    @(posedge clock) ea_valid <= 1'b0;
    #1 `CHK({x_valid, x_addr, x_word}, {1'b1, r.e, |r.wf})
    @(posedge clock);
  endtask : ea
  task automatic mac(input logic [35:0] d);
    {mac_addend, mac_valid} <= {d, 1'b1};
    @(posedge clock) mac_valid <= 1'b0;
    @(posedge clock);
  endtask : mac
  task automatic macrd(input logic x, input logic [31:0] e);
    {mac_ext, mac_read} <= {x, 1'b1};
    @(posedge clock) mac_read <= 1'b0;
    #1 `CHK({mac_dv, mac_data}, {1'b1, e})
    @(posedge clock);
  endtask : macrd
  task automatic stop_pulse(input logic e);
    low_power_stop_instr <= 1'b1;
    @(posedge clock) low_power_stop_instr <= 1'b0;
    #1 `CHK(clk_stop, e)
  endtask : stop_pulse
  // a hang costs a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 `CHK({int_level, pc_addr, clk_stop}, {3'h7, 20'h00000, 1'b0})
    rdchk(cfa_pkg::ADDR_CCR, 16'hffff, cfa_pkg::CCR_RESET);
    foreach (alu_rows[i]) alu(alu_rows[i]);
    wr(4'hf, 16'hffff);
    rdchk(4'hf, 16'hffff, 16'h0000);
    wr(cfa_pkg::ADDR_BANK, 16'h2345);
    wr(cfa_pkg::ADDR_IDX_X, 16'hfff0);
    wr(cfa_pkg::ADDR_IDX_Y, 16'h1000);
    wr(cfa_pkg::ADDR_IDX_Z, 16'h0100);
    wr(cfa_pkg::ADDR_ACC_E, 16'h0020);
    wr(cfa_pkg::ADDR_PC, 16'h1234);
    wr(cfa_pkg::ADDR_CCR, 16'h00e1);
    #1 `CHK(pc_addr, 20'h11234)
    foreach (ea_rows[i]) ea(ea_rows[i]);
    rdchk(cfa_pkg::ADDR_IDX_X, 16'hffff, 16'hfff0);
    rdchk(cfa_pkg::ADDR_PC, 16'hffff, 16'h1242);
    // ******************************
    // split word, then a request dropped while busy
    // ******************************
    {ea_mode, ea_operand, ea_word, ea_fetch, ea_valid} <= {4'h1, 20'h0ffff, 3'h5};
    @(posedge clock);
    #1 `CHK({x_valid, x_addr, x_word, ea_busy}, {1'b1, 20'h2ffff, 2'h1})
    ea_operand <= 20'h00000;
    @(posedge clock) ea_valid <= 1'b0;
    #1 `CHK({x_valid, x_addr, x_word, ea_busy}, {1'b1, 20'h30000, 2'h0})
    @(posedge clock);
    #1 `CHK({x_valid, x_count, mis}, {1'b0, 8'h0e, 1'b0})
    wr(cfa_pkg::ADDR_CCR, 16'h00f1);
    mac(36'h000001234);
    macrd(1'b1, 32'h00001234);
    mac(36'h07ffff000);
    rdchk(cfa_pkg::ADDR_CCR, 16'h5000, 16'h1000);
    macrd(1'b1, 32'h7fffffff);
    macrd(1'b0, 32'h00007fff);
    mac(36'h780000000);
    rdchk(cfa_pkg::ADDR_CCR, 16'h4000, 16'h4000);
    rdchk(cfa_pkg::ADDR_AM_HI, 16'hffff, 16'h0008);
    rdchk(cfa_pkg::ADDR_AM_LO, 16'hffff, 16'h0234);
    macrd(1'b1, 32'h7fffffff);
    wr(cfa_pkg::ADDR_CCR, 16'h00e1);
    macrd(1'b1, 32'h00000234);
    stop_pulse(1'b1);
    rdchk(cfa_pkg::ADDR_STATUS, 16'hffff, 16'h0001);
    wake <= 1'b1;
    @(posedge clock) wake <= 1'b0;
    #1 `CHK(clk_stop, 1'b0)
    wr(cfa_pkg::ADDR_CCR, 16'h8041);
    #1 `CHK(int_level, 3'h2)
    stop_pulse(1'b0);
    resetn <= 1'b0;
    @(posedge clock) resetn <= 1'b1;
    @(posedge clock);
    rdchk(cfa_pkg::ADDR_CCR, 16'hffff, cfa_pkg::CCR_RESET);
    close_out();
  end
endmodule : tb
